/* verilog/cio_pkg.sv */
// Purpose: shared constants and types for the configurable I/O port block
// Assumes: seven ports A..G, eight pins each; port D direction register holds only four bits
// Notes:   register offsets inside the I/O register space are arbitrary
`default_nettype none
package cio_pkg;
  localparam int          CIO_NPORT     = 7;
  localparam int          CIO_W         = 8;
  localparam logic [2:0]  CIO_PA        = 3'h0;
  localparam logic [2:0]  CIO_PB        = 3'h1;
  localparam logic [2:0]  CIO_PC        = 3'h2;
  localparam logic [2:0]  CIO_PD        = 3'h3;
  localparam logic [2:0]  CIO_PE        = 3'h4;
  localparam logic [2:0]  CIO_PF        = 3'h5;
  localparam logic [2:0]  CIO_PG        = 3'h6;
  // register kind in address bits [6:4], port in bits [2:0]
  localparam logic [2:0]  CIO_K_MODE    = 3'h0;
  localparam logic [2:0]  CIO_K_DIR     = 3'h1;
  localparam logic [2:0]  CIO_K_DRIVE   = 3'h2;
  localparam logic [2:0]  CIO_K_DOUT    = 3'h3;
  localparam logic [2:0]  CIO_K_DIN     = 3'h4;
  localparam logic [2:0]  CIO_K_IMC     = 3'h5;
  localparam logic [2:0]  CIO_K_OEN     = 3'h6;
  localparam logic [2:0]  CIO_K_MMAP    = 3'h7;
  localparam logic [7:0]  CIO_RST_VAL   = 8'h00;
  localparam logic [7:0]  CIO_PD_MASK   = 8'h0F;
  localparam int          CIO_PIO_BIT   = 7;
  localparam logic [6:0]  CIO_MODE_PRTS = 7'h70; // E F G
  localparam logic [6:0]  CIO_DRV_PRTS  = 7'h5B; // A B D E G
  localparam logic [6:0]  CIO_IMC_PRTS  = 7'h07; // A B C

  typedef enum logic [1:0] {
    CIO_IMC_DIRECT, CIO_IMC_LATCH, CIO_IMC_REG
  } cio_imc_e;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [6:0] addr;
    logic [7:0] wdata;
  } cio_bus_s;

  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } cio_pin_s;
endpackage : cio_pkg
`default_nettype wire

/* verilog/cio_pin_sync.sv */
// Purpose: three-flop pin synchroniser, output moves when stages 2, 3 agree
// Assumes: pin inputs are asynchronous to clk
// Notes:   stage one feeds stage two only
`default_nettype none
module cio_pin_sync
  import cio_pkg::*;
(
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [7:0]   pin_in,
  output logic      [7:0]   pin_sync
);
  logic [7:0] s1;
  logic [7:0] s2;
  logic [7:0] s3;
  wire  [7:0] agree = ~(s2 ^ s3);
  wire  [7:0] next_sync = (agree & s3) | (~agree & pin_sync);

  always_ff @(posedge clk) begin
    if (rst) begin
      s1       <= CIO_RST_VAL;
      s2       <= CIO_RST_VAL;
      s3       <= CIO_RST_VAL;
      pin_sync <= CIO_RST_VAL;
    end else begin
      s1       <= pin_in;
      s2       <= s1;
      s3       <= s2;
      pin_sync <= next_sync;
    end
  end
endmodule // cio_pin_sync
`default_nettype wire

/* verilog/cio_port_block.sv */
// Purpose: configurable I/O port block, ports A..G
// Assumes: host strobes already synchronous to clk; logic-array terms on clk
// Notes:   configuration-time choices arrive as static inputs
//
// Operation
// - driver enable is array OE OR direction
// - without OE term, direction alone drives
// - config registers read back by host
// - A/B/C input macrocells: latch, register, direct
// - mode bit 0 general I/O, 1 address
// - direction 1 output, 0 input, default input
// - output from data-out, input via data-in
// - A/B/C no mode register, general I/O
// - address out needs OE or dir and mode
// - address bytes mapped onto ports E F G
// - high address inputs latched by address strobe
// - data-port mode disables F/G general I/O
// - map register bit 7 enables peripheral mode
// - peripheral buffer off without select terms
// - strapping pattern driven during reset, bus idle
// - after reset, data port resumes
// - bit n controls pin n, reset zero
// - port D direction only four bits
// - drive-select 1 open drain, else push-pull
// - drive-select on A,B,D,E,G; mode on E,F,G
// - scan programming shares port E pins
// - output-enable status readable
`default_nettype none
module cio_port_block
  import cio_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire cio_bus_s         bus,
  output logic      [7:0]       rdata,
  input  wire logic [15:0]      host_addr,
  input  wire logic             addr_strobe,
  input  wire logic             eight_bit_host,
  input  wire logic             nonmux_host,
  input  wire logic [15:0]      host_wdata,
  output logic      [15:0]      host_rdata,
  output logic      [15:0]      host_rdata_oe,
  input  wire logic             bus_cycle_active,
  input  wire logic             host_reset,
  input  wire logic             strap_mode,
  input  wire logic [15:0]      strap_pattern,
  input  wire logic             periph_sel_a,
  input  wire logic             periph_sel_b,
  input  wire logic [7:0]       periph_data,
  output logic      [7:0]       periph_rdata,
  input  wire logic [55:0]      array_oe,
  input  wire logic [55:0]      array_oe_defined,
  input  wire logic [55:0]      array_out,
  input  wire logic [55:0]      array_out_sel,
  input  wire logic [47:0]      imc_mode,
  input  wire logic [23:0]      imc_pt_clk,
  input  wire logic [23:0]      imc_use_pt,
  output logic      [23:0]      imc_out,
  output logic      [55:0]      pin_sync_out,
  input  wire logic             scan_enable,
  input  wire logic [7:0]       scan_out,
  input  wire logic [7:0]       scan_oe,
  input  wire logic [55:0]      pin_in,
  output logic      [55:0]      pin_out,
  output logic      [55:0]      pin_oe
);
  logic [7:0] mode_r  [CIO_NPORT];
  logic [7:0] dir_r   [CIO_NPORT];
  logic [7:0] drive_r [CIO_NPORT];
  logic [7:0] dout_r  [CIO_NPORT];
  logic [7:0] imc_r   [3];
  logic [7:0] mmap_r;
  logic [7:0] oe_stat [CIO_NPORT];
  logic       as_q;

  wire  [2:0] k       = bus.addr[6:4];
  wire  [2:0] p       = bus.addr[2:0];
  wire        p_ok    = (p < 3'(CIO_NPORT));
  wire        pio_en  = mmap_r[CIO_PIO_BIT];
  wire        psel    = periph_sel_a | periph_sel_b;
  wire        as_rise = addr_strobe & ~as_q;
  wire        strap_drv = strap_mode & host_reset & ~bus_cycle_active;
  wire [55:0] pin_s;
  wire [7:0]  wmask_d = (p == CIO_PD) ? CIO_PD_MASK : 8'hFF;

  genvar gi;
  generate
    for (gi = 0; gi < CIO_NPORT; gi++) begin : g_sync
      cio_pin_sync u_s (
        .clk      (clk),
        .rst      (rst),
        .pin_in   (pin_in[gi*8 +: 8]),
        .pin_sync (pin_s[gi*8 +: 8])
      );
    end
  endgenerate

  // register writes; unsupported registers/bits stay zero
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < CIO_NPORT; i++) begin
        mode_r[i]  <= CIO_RST_VAL;
        dir_r[i]   <= CIO_RST_VAL;
        drive_r[i] <= CIO_RST_VAL;
        dout_r[i]  <= CIO_RST_VAL;
      end
      mmap_r <= CIO_RST_VAL;
      as_q   <= 1'b0;
    end else begin
      as_q <= addr_strobe;
      if (bus.wr && p_ok) begin
        case (k)
          CIO_K_MODE:  if (CIO_MODE_PRTS[p]) mode_r[p] <= bus.wdata;
          CIO_K_DIR:   dir_r[p] <= bus.wdata & wmask_d;
          CIO_K_DRIVE: if (CIO_DRV_PRTS[p]) drive_r[p] <= bus.wdata;
          CIO_K_DOUT:  dout_r[p] <= bus.wdata;
          CIO_K_MMAP:  mmap_r <= bus.wdata;
          default: ;
        endcase
      end
    end
  end

  // input macrocells on A, B, C
  generate
    for (gi = 0; gi < 24; gi++) begin : g_imc
      wire ck = imc_use_pt[gi] ? imc_pt_clk[gi] : as_rise;
      wire cio_imc_e m = cio_imc_e'(imc_mode[gi*2 +: 2]);
      always_ff @(posedge clk) begin
        if (rst) begin
          imc_r[gi/8][gi%8] <= 1'b0;
        end else if (m == CIO_IMC_LATCH && (imc_use_pt[gi] ?
                     imc_pt_clk[gi] : addr_strobe)) begin
          imc_r[gi/8][gi%8] <= pin_s[gi];
        end else if (m == CIO_IMC_REG && ck) begin
          imc_r[gi/8][gi%8] <= pin_s[gi];
        end
      end
      assign imc_out[gi] = (m == CIO_IMC_DIRECT) ? pin_s[gi]
                                                 : imc_r[gi/8][gi%8];
    end
  endgenerate

  // per-pin output selection
  logic [55:0] next_out;
  logic [55:0] next_oe;
  logic [7:0]  addr_src [CIO_NPORT];
  always_comb begin
    for (int i = 0; i < CIO_NPORT; i++) addr_src[i] = 8'h00;
    addr_src[CIO_PE] = host_addr[7:0];
    addr_src[CIO_PF] = host_addr[7:0];
    addr_src[CIO_PG] = eight_bit_host ? host_addr[7:0]
                                      : host_addr[15:8];
    for (int i = 0; i < 56; i++) begin
      automatic int    pt = i / 8;
      automatic int    b  = i % 8;
      automatic logic  d  = dir_r[pt][b];
      automatic logic  te = array_oe_defined[i] & array_oe[i];
      automatic logic  en = te | d;
      if (!array_oe_defined[i] && !array_out_sel[i])
        en = d;
      if (mode_r[pt][b])
        next_out[i] = addr_src[pt][b];
      else if (array_out_sel[i])
        next_out[i] = array_out[i];
      else
        next_out[i] = dout_r[pt][b];
      // open drain drives only lows
      if (drive_r[pt][b])
        en = en & ~next_out[i];
      next_oe[i] = en;
    end
    if (scan_enable) begin
      next_out[39:32] = scan_out;
      next_oe[39:32]  = scan_oe;
    end
    if (pio_en) begin
      next_out[47:40] = periph_data;
      next_oe[47:40]  = {8{psel & ~bus.rd}};
    end
    if (nonmux_host) begin
      next_out[55:40] = host_wdata;
      next_oe[55:40]  = 16'h0000;
    end
    if (strap_drv) begin
      next_out[55:40] = strap_pattern;
      next_oe[55:40]  = 16'hFFFF;
    end
  end

  wire [15:0] fg_in = pin_s[55:40];
  always_ff @(posedge clk) begin
    if (rst) begin
      pin_out       <= 56'h0;
      pin_oe        <= 56'h0;
      host_rdata    <= 16'h0000;
      host_rdata_oe <= 16'h0000;
      periph_rdata  <= 8'h00;
      pin_sync_out  <= 56'h0;
      for (int i = 0; i < CIO_NPORT; i++) oe_stat[i] <= 8'h00;
    end else begin
      pin_out      <= next_out;
      pin_oe       <= next_oe;
      pin_sync_out <= pin_s;
      for (int i = 0; i < CIO_NPORT; i++)
        oe_stat[i] <= next_oe[i*8 +: 8];
      // data-port read path; strapping ends with host reset
      host_rdata    <= fg_in;
      host_rdata_oe <= {16{nonmux_host & bus.rd & ~strap_drv}};
      periph_rdata  <= (pio_en && psel && bus.rd) ?
                       pin_s[47:40] : 8'h00;
    end
  end

  // readback mux
  logic [7:0] next_rdata;
  always_comb begin
    next_rdata = 8'h00;
    if (bus.rd && p_ok) begin
      case (k)
        CIO_K_MODE:  next_rdata = mode_r[p];
        CIO_K_DIR:   next_rdata = dir_r[p];
        CIO_K_DRIVE: next_rdata = drive_r[p];
        CIO_K_DOUT:  next_rdata = dout_r[p];
        CIO_K_DIN:   next_rdata = pin_s[p*8 +: 8];
        CIO_K_IMC:   next_rdata = CIO_IMC_PRTS[p] ?
                                  imc_out[p*8 +: 8] : 8'h00;
        CIO_K_OEN:   next_rdata = oe_stat[p];
        CIO_K_MMAP:  next_rdata = mmap_r;
        default:     next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) rdata <= 8'h00;
    else     rdata <= next_rdata;
  end

  a_dir_reset: assert property (@(posedge clk)
    $fell(rst) |-> dir_r[0] == 8'h00 && pin_oe == 56'h0)
    else $error("direction not cleared by reset");
  a_pd_dir_width: assert property (@(posedge clk) disable iff (rst)
    dir_r[3][7:4] == 4'h0)
    else $error("port D upper direction bits set");
  a_no_mode_abc: assert property (@(posedge clk) disable iff (rst)
    mode_r[0] == 8'h00 && mode_r[1] == 8'h00 && mode_r[2] == 8'h00)
    else $error("mode register on port without one");
  a_dir_drives: assert property (@(posedge clk) disable iff (rst)
    dir_r[0][1] && !drive_r[0][1] |=> pin_oe[1])
    else $error("direction bit failed to enable driver");
  a_gpio_value: assert property (@(posedge clk) disable iff (rst)
    !array_out_sel[8] && mode_r[1][0] == 1'b0 && !pio_en && !scan_enable
    |=> pin_out[8] == $past(dout_r[1][0]))
    else $error("output not from data-out");
  a_periph_off: assert property (@(posedge clk) disable iff (rst)
    pio_en && !psel && !nonmux_host && !strap_drv |=> pin_oe[47:40] == 8'h00)
    else $error("peripheral buffer driven without select");
  a_strap_drive: assert property (@(posedge clk) disable iff (rst)
    strap_drv |=> pin_oe[55:40] == 16'hFFFF &&
                  pin_out[55:40] == $past(strap_pattern))
    else $error("strapping pattern not driven");
  a_readback_dir: assert property (@(posedge clk) disable iff (rst)
    bus.rd && bus.addr == {CIO_K_DIR, 1'b0, CIO_PE}
    |=> rdata == $past(dir_r[4]))
    else $error("direction readback wrong");
  a_oe_status: assert property (@(posedge clk) disable iff (rst)
    bus.rd && bus.addr == {CIO_K_OEN, 1'b0, CIO_PE}
    |=> rdata == $past(pin_oe[39:32]))
    else $error("output-enable status mismatch");
  // pin checks leave out the port-wide overrides that outrank them
  a_addr_out_oe: assert property (@(posedge clk) disable iff (rst)
    !scan_enable && mode_r[4][0] && !dir_r[4][0] &&
    !(array_oe_defined[32] && array_oe[32]) |=> !pin_oe[32])
    else $error("address output driven without direction");
  a_addr_map: assert property (@(posedge clk) disable iff (rst)
    mode_r[6][0] && !nonmux_host && !strap_drv
    |=> pin_out[48] == $past(eight_bit_host ? host_addr[0] : host_addr[8]))
    else $error("port G address bit wrong");
  a_open_drain: assert property (@(posedge clk) disable iff (rst)
    drive_r[4][0] && !scan_enable |=> !(pin_oe[32] && pin_out[32]))
    else $error("open-drain pin driven high");
  a_scan_share: assert property (@(posedge clk) disable iff (rst)
    scan_enable |=> pin_out[39:32] == $past(scan_out) &&
                    pin_oe[39:32] == $past(scan_oe))
    else $error("scan pins not on port E");
  a_pio_drive: assert property (@(posedge clk) disable iff (rst)
    pio_en && psel && !bus.rd && !nonmux_host && !strap_drv
    |=> pin_oe[47:40] == 8'hFF && pin_out[47:40] == $past(periph_data))
    else $error("peripheral buffer not driving port F");
  a_periph_read: assert property (@(posedge clk) disable iff (rst)
    pio_en && psel && bus.rd && !nonmux_host && !strap_drv
    |=> pin_oe[47:40] == 8'h00 && periph_rdata == $past(pin_s[47:40]))
    else $error("peripheral read path wrong");
  a_dataport_off: assert property (@(posedge clk) disable iff (rst)
    nonmux_host && !strap_drv |=> pin_oe[55:40] == 16'h0000)
    else $error("data port pins driven as general I/O");
  a_strap_release: assert property (@(posedge clk) disable iff (rst)
    $fell(strap_drv) && nonmux_host |=> pin_oe[55:40] == 16'h0000)
    else $error("strapping drive kept after reset");
  a_imc_hold: assert property (@(posedge clk) disable iff (rst)
    imc_mode[33:32] == 2'd1 && !imc_use_pt[16] && !addr_strobe
    |=> $stable(imc_r[2][0]))
    else $error("input latch changed with strobe low");
endmodule // cio_port_block
`default_nettype wire

/* testbench/cio_pin_partner.sv */
// Purpose: outside world at the port pins, pull-ups plus outside drivers
// Assumes: every pin carries an external pull-up
// Notes:   while the device drives a pin, its value wins
`default_nettype none
module cio_pin_partner (
  input  wire logic [55:0] pin_out,
  input  wire logic [55:0] pin_oe,
  input  wire logic [55:0] ext_val,
  input  wire logic [55:0] ext_en,
  output logic      [55:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ns;
  // released lines float high, open-drain highs depend on it
  always_comb begin
    for (int i = 0; i < 56; i++) begin
      if (pin_oe[i]) begin  // device driver owns the line
        pin_in[i] = pin_out[i];
      end else if (ext_en[i]) begin  // only on pins left as inputs
        pin_in[i] = ext_val[i];
      end else begin
        pin_in[i] = 1'b1;
      end
    end
  end
endmodule // cio_pin_partner
`default_nettype wire

/* testbench/tb.sv */
// Purpose: self-checking bench for the configurable I/O port block
// Assumes: inputs change on the falling edge, pins pulled up
// Notes:   pin effects settle two edges after a register write
`default_nettype none
module tb
  import cio_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic [6:0] addr;
    logic [7:0] wdata;
    logic [7:0] exp;
  } cio_row_s;
  logic clk = 1'b0, rst = 1'b1, addr_strobe = 1'b0, eight_bit_host = 1'b0;
  logic nonmux_host = 1'b0, bus_cycle_active = 1'b0, host_reset = 1'b0;
  logic strap_mode = 1'b0, periph_sel_a = 1'b0, periph_sel_b = 1'b0;
  logic scan_enable = 1'b0;
  cio_bus_s    bus = '0;
  logic [15:0] host_addr = '0, host_wdata = '0, strap_pattern = '0;
  logic [7:0]  periph_data = '0, scan_out = '0, scan_oe = '0;
  logic [55:0] array_oe = '0, array_oe_defined = '0, array_out = '0;
  logic [55:0] array_out_sel = '0, ext_val = '0, ext_en = '0;
  logic [47:0] imc_mode = '0;
  logic [23:0] imc_pt_clk = '0, imc_use_pt = '0;
  logic [7:0]  rdata, periph_rdata;
  logic [15:0] host_rdata, host_rdata_oe;
  logic [23:0] imc_out;
  logic [55:0] pin_sync_out, pin_in, pin_out, pin_oe;
  int          n_mismatch = 0;
  int          tests_run = 0;
  // register rows: address, value written, value read back
  cio_row_s rows[9] = '{
    '{7'h14, 8'hA5, 8'hA5}, '{7'h13, 8'hFF, 8'h0F}, '{7'h00, 8'hFF, 8'h00},
    '{7'h06, 8'h3C, 8'h3C}, '{7'h22, 8'hFF, 8'h00}, '{7'h25, 8'hFF, 8'h00},
    '{7'h26, 8'h81, 8'h81}, '{7'h17, 8'hFF, 8'h00}, '{7'h06, 8'h00, 8'h00}};

  cio_port_block cio_port_block_i (.clk, .rst, .bus, .rdata, .host_addr,
    .addr_strobe, .eight_bit_host, .nonmux_host, .host_wdata, .host_rdata,
    .host_rdata_oe, .bus_cycle_active, .host_reset, .strap_mode,
    .strap_pattern, .periph_sel_a, .periph_sel_b, .periph_data,
    .periph_rdata, .array_oe, .array_oe_defined, .array_out, .array_out_sel,
    .imc_mode, .imc_pt_clk, .imc_use_pt, .imc_out, .pin_sync_out,
    .scan_enable, .scan_out, .scan_oe, .pin_in, .pin_out, .pin_oe);
  cio_pin_partner cio_pin_partner_i (.pin_out, .pin_oe, .ext_val, .ext_en,
    .pin_in);

  always #25 clk = ~clk;

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(negedge clk);
    bus = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge clk);
    bus = '0;
  endtask
  // read data is registered, so it is looked at one edge later
  task automatic rd_chk(input logic [6:0] a, input logic [7:0] e);
    @(negedge clk);
    bus = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge clk);
    bus = '0;
    chk(16'(rdata), 16'(e));
  endtask
  task automatic settle;
    repeat (6) @(negedge clk);
  endtask

  // a hang counts as a mismatch
  initial begin
    repeat (4000) @(posedge clk);
    n_mismatch++;
    tally_and_finish();
  end

  initial begin
    repeat (5) @(negedge clk);
    rst = 1'b0;
    for (int p = 0; p < 7; p++) begin
      for (int k = 0; k < 3; k++) begin
        rd_chk({k[2:0], 1'b0, p[2:0]}, CIO_RST_VAL);
      end
    end
    foreach (rows[i]) begin
      wr(rows[i].addr, rows[i].wdata);
      rd_chk(rows[i].addr, rows[i].exp);
    end
    wr(7'h14, 8'h0F);
    wr(7'h34, 8'h5A);
    settle();
    chk(16'(pin_oe[39:32]), 16'h000F);
    chk(16'(pin_out[35:32]), 16'h000A);
    rd_chk(7'h64, 8'h0F);
    wr(7'h24, 8'hFF);
    settle();
    chk(16'(pin_oe[39:32]), 16'h0005);
    wr(7'h24, 8'h00);
    array_oe[0] = 1'b1;
    array_oe_defined[0] = 1'b1;
    wr(7'h10, 8'h02);
    settle();
    chk(16'(pin_oe[7:0]), 16'h0003);
    array_out_sel[9] = 1'b1;
    array_out[9] = 1'b1;
    wr(7'h31, 8'h81);
    wr(7'h11, 8'hFF);
    settle();
    chk(16'(pin_out[15:8]), 16'h0083);
    chk(16'(pin_oe[15:8]), 16'h00FF);
    rd_chk(7'h41, 8'h83);
    ext_en[23:16] = 8'hFF;
    ext_val[23:16] = 8'hC3;
    settle();
    rd_chk(7'h42, 8'hC3);
    chk(16'(imc_out[23:16]), 16'h00C3);
    imc_mode[33:32] = 2'd1;
    imc_mode[35:34] = 2'd2;
    addr_strobe = 1'b1;
    settle();
    addr_strobe = 1'b0;
    ext_val[23:16] = 8'h3C;
    settle();
    chk(16'(imc_out[17:16]), 16'h0003);
    addr_strobe = 1'b1;
    settle();
    addr_strobe = 1'b0;
    chk(16'(imc_out[17:16]), 16'h0000);
    rd_chk(7'h52, 8'h3C);
    // address out: mode alone must not drive
    wr(7'h04, 8'hFF);
    wr(7'h14, 8'h00);
    settle();
    chk(16'(pin_oe[39:32]), 16'h0000);
    host_addr = 16'hBEEF;
    wr(7'h14, 8'hFF);
    wr(7'h06, 8'hFF);
    wr(7'h16, 8'hFF);
    settle();
    chk(16'(pin_out[39:32]), 16'h00EF);
    chk(16'(pin_out[55:48]), 16'h00BE);
    eight_bit_host = 1'b1;
    settle();
    chk(16'(pin_out[55:48]), 16'h00EF);
    scan_enable = 1'b1;
    scan_out = 8'hA5;
    scan_oe = 8'hFF;
    settle();
    chk({pin_oe[39:32], pin_out[39:32]}, 16'hFFA5);
    scan_enable = 1'b0;
    wr(7'h16, 8'h00);
    wr(7'h06, 8'h00);
    wr(7'h70, 8'h80);
    rd_chk(7'h70, 8'h80);
    periph_data = 8'h69;
    settle();
    chk(16'(pin_oe[47:40]), 16'h0000);
    periph_sel_b = 1'b1;
    settle();
    chk({pin_oe[47:40], pin_out[47:40]}, 16'hFF69);
    rd_chk(7'h70, 8'h80);
    chk(16'(periph_rdata), 16'h0069);
    chk(16'(pin_oe[47:40]), 16'h0000);
    periph_sel_b = 1'b0;
    wr(7'h70, 8'h00);
    strap_mode = 1'b1;
    strap_pattern = 16'h1E5A;
    host_reset = 1'b1;
    bus_cycle_active = 1'b1;
    settle();
    chk(pin_oe[55:40], 16'h0000);
    bus_cycle_active = 1'b0;
    settle();
    chk(pin_oe[55:40], 16'hFFFF);
    chk(pin_out[55:40], 16'h1E5A);
    host_reset = 1'b0;
    nonmux_host = 1'b1;
    ext_en[55:40] = 16'hFFFF;
    ext_val[55:40] = 16'h2B71;
    settle();
    chk(host_rdata, 16'h2B71);
    rd_chk(7'h15, 8'h00);
    chk(host_rdata_oe, 16'hFFFF);
    chk(pin_sync_out[55:40], 16'h2B71);
    wr(7'h15, 8'hFF);
    settle();
    chk(pin_oe[55:40], 16'h0000);
    // second reset in mid-run
    rst = 1'b1;
    repeat (2) @(negedge clk);
    chk(pin_oe[15:0], 16'h0000);
    rst = 1'b0;
    rd_chk(7'h15, 8'h00);
    tally_and_finish();
  end
endmodule // tb
`default_nettype wire
